// ==== hw/lcd_driver.sv ====
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module lcd_driver
  import lcd_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  input  wire logic                  SUB_CLOCK,
  input  wire logic                  SLEEP,
  input  wire logic [lcd_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [lcd_pkg::DATA_W-1:0] WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [lcd_pkg::DATA_W-1:0] RDATA,
  output logic                       LCD_RESET,
  output logic [7:0]                 COM_LEVEL,
  output logic [31:0]                SEG_LEVEL,
  output logic [15:0]                SEG_CMOS_EN,
  output logic [15:0]                SEG_CMOS_OUT
);
  import lcd_pkg::*;

  logic [7:0] display_control_reg;
  logic [7:0] portc_segment_select;
  logic [7:0] portd_segment_select;
  logic [7:0] bank_pointer_reg;
  logic [7:0] indirect_pointer_one;
  logic [3:0] dmem [DMEM_WORDS];
  logic [7:0] gmem [GMEM_WORDS];
  logic       sleep_s1;
  logic       sleep_s2;
  logic       tick;
  logic [1:0] slot;
  logic       pol;
  logic [15:0] select_all;
  logic       display_enable_bit;
  logic       wave_type;

  function automatic logic in_display(input logic [7:0] a);
    in_display = (a >= DMEM_BASE) && (a <= DMEM_LAST);
  endfunction

  wire indir_disp = (bank_pointer_reg == BANK_DISPLAY) &&
                    in_display(indirect_pointer_one);
  wire [3:0] dm_idx = indirect_pointer_one[3:0];

  assign display_enable_bit = display_control_reg[CTRL_EN_BIT];
  assign wave_type = display_control_reg[CTRL_TYPE_BIT];
  assign select_all = {portd_segment_select, portc_segment_select};

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end else begin
      sleep_s1 <= SLEEP;
      sleep_s2 <= sleep_s1;
    end
  end

  // Sleep overrides the enable bit regardless of what software wrote.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      LCD_RESET <= 1'b1;
    end else begin
      LCD_RESET <= sleep_s2 | ~display_enable_bit;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      display_control_reg  <= ZERO8;
      portc_segment_select <= SELECT_RST;
      portd_segment_select <= SELECT_RST;
      bank_pointer_reg     <= ZERO8;
      indirect_pointer_one <= ZERO8;
    end else if (WR) begin
      unique case (ADDR)
        ADDR_CTRL:    display_control_reg  <= WDATA & CTRL_MASK;
        ADDR_PORTC:   portc_segment_select <= WDATA;
        ADDR_PORTD:   portd_segment_select <= WDATA;
        ADDR_BANK:    bank_pointer_reg     <= WDATA;
        ADDR_POINTER: indirect_pointer_one <= WDATA;
        default: ;
      endcase
    end
  end

  // Display memory powers up undefined; software must fill it.
  always_ff @(posedge CLK) begin
    if (WR && ADDR == ADDR_INDIR && indir_disp) begin
      dmem[dm_idx] <= WDATA[3:0];
    end
  end

  // Direct accesses to the display range land in general memory.
  always_ff @(posedge CLK) begin
    if (WR && ADDR == ADDR_INDIR && !indir_disp) begin
      gmem[indirect_pointer_one] <= WDATA;
    end else if (WR && in_display(ADDR)) begin
      gmem[ADDR] <= WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      RDATA <= ZERO8;
    end else if (RD) begin
      if (in_display(ADDR)) begin
        RDATA <= gmem[ADDR];
      end else begin
        unique case (ADDR)
          ADDR_CTRL:    RDATA <= display_control_reg;
          ADDR_PORTC:   RDATA <= portc_segment_select;
          ADDR_PORTD:   RDATA <= portd_segment_select;
          ADDR_BANK:    RDATA <= bank_pointer_reg;
          ADDR_POINTER: RDATA <= indirect_pointer_one;
          ADDR_INDIR:   RDATA <= indir_disp ? {4'h0, dmem[dm_idx]}
                                            : gmem[indirect_pointer_one];
          default:      RDATA <= ZERO8;
        endcase
      end
    end else begin
      RDATA <= ZERO8;
    end
  end

  lcd_sub_tick #(.DIV(SUB_DIV)) u_tick (
    .CLK       (CLK),
    .NRST      (NRST),
    .SUB_CLOCK (SUB_CLOCK),
    .TICK      (tick)
  );

  lcd_wave_gen u_wave (
    .CLK       (CLK),
    .NRST      (NRST),
    .TICK      (tick),
    .LCD_RESET (LCD_RESET),
    .WAVE_TYPE (wave_type),
    .SLOT      (slot),
    .PHASE     (),
    .POL       (pol)
  );

  // Selected common sits at VA or ground, others at VC or VB, swapping
  // with polarity so every pixel sees zero average voltage.
  genvar c;
  generate
    for (c = 0; c < NUM_COM; c++) begin : g_com
      always_ff @(posedge CLK) begin
        if (!NRST || LCD_RESET) begin
          COM_LEVEL[2*c +: 2] <= LVL_GND;
        end else if (slot == 2'(c)) begin
          COM_LEVEL[2*c +: 2] <= pol ? LVL_GND : LVL_A;
        end else begin
          COM_LEVEL[2*c +: 2] <= pol ? LVL_B : LVL_C;
        end
      end
    end
  endgenerate

  // Each segment reads its memory nibble live every slot.
  genvar s;
  generate
    for (s = 0; s < NUM_SEG; s++) begin : g_seg
      wire on = dmem[s][slot];
      always_ff @(posedge CLK) begin
        if (!NRST || LCD_RESET || !select_all[s]) begin
          SEG_LEVEL[2*s +: 2] <= LVL_GND;
        end else if (on) begin
          SEG_LEVEL[2*s +: 2] <= pol ? LVL_A : LVL_GND;
        end else begin
          SEG_LEVEL[2*s +: 2] <= pol ? LVL_C : LVL_B;
        end
      end
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          SEG_CMOS_EN[s]  <= 1'b0;
          SEG_CMOS_OUT[s] <= 1'b0;
        end else begin
          SEG_CMOS_EN[s]  <= ~select_all[s];
          SEG_CMOS_OUT[s] <= ~select_all[s] & dmem[s][0];
        end
      end
    end
  endgenerate

  property p_reset_cause;
    @(posedge CLK) disable iff (!NRST)
      LCD_RESET == $past(sleep_s2 | ~display_enable_bit);
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("LCD reset does not follow sleep or enable.");

  property p_sleep_off;
    @(posedge CLK) disable iff (!NRST)
      sleep_s2 |=> LCD_RESET;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("Display stays on in sleep.");

  property p_blank;
    @(posedge CLK) disable iff (!NRST)
      LCD_RESET |=> (COM_LEVEL == '0) && (SEG_LEVEL == '0);
  endproperty
  a_blank: assert property (p_blank)
    else $error("Panel drive active while LCD reset.");

  property p_slot_home;
    @(posedge CLK) disable iff (!NRST)
      LCD_RESET |=> slot == 2'h0;
  endproperty
  a_slot_home: assert property (p_slot_home)
    else $error("Sequencer not at first slot under LCD reset.");

  property p_ctrl_reset;
    @(posedge CLK) !NRST |=> display_control_reg == ZERO8 &&
      portc_segment_select == SELECT_RST && portd_segment_select == SELECT_RST;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("Register reset values wrong.");

  property p_cmos;
    @(posedge CLK) disable iff (!NRST)
      !select_all[0] |=> SEG_CMOS_EN[0] && SEG_LEVEL[1:0] == 2'h0;
  endproperty
  a_cmos: assert property (p_cmos)
    else $error("CMOS-selected pin still driven as segment.");

  property p_type_b_hold;
    @(posedge CLK) disable iff (!NRST)
      wave_type && $stable(wave_type) && !LCD_RESET && tick &&
        slot != 2'h3 && !(WR && ADDR == ADDR_CTRL) |=> $stable(pol);
  endproperty
  a_type_b_hold: assert property (p_type_b_hold)
    else $error("Type B polarity changed inside a frame.");

  property p_one_com;
    @(posedge CLK) disable iff (!NRST)
      !LCD_RESET && !$past(LCD_RESET) |->
        $countones({COM_LEVEL[7:6] inside {LVL_A, LVL_GND},
                    COM_LEVEL[5:4] inside {LVL_A, LVL_GND},
                    COM_LEVEL[3:2] inside {LVL_A, LVL_GND},
                    COM_LEVEL[1:0] inside {LVL_A, LVL_GND}}) == 1;
  endproperty
  a_one_com: assert property (p_one_com)
    else $error("Not exactly one common selected.");

  property p_ctrl_mask;
    @(posedge CLK) disable iff (!NRST)
      (display_control_reg & ~CTRL_MASK) == ZERO8;
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask)
    else $error("Reserved control bits are set.");

  property p_direct_gmem;
    @(posedge CLK) disable iff (!NRST)
      WR && ADDR == DMEM_BASE |=> gmem[DMEM_BASE] == $past(WDATA);
  endproperty
  a_direct_gmem: assert property (p_direct_gmem)
    else $error("Direct display-range write missed general memory.");

  property p_indir_dmem;
    @(posedge CLK) disable iff (!NRST)
      WR && ADDR == ADDR_INDIR && indir_disp && dm_idx == 4'h3
        |=> dmem[3] == $past(WDATA[3:0]);
  endproperty
  a_indir_dmem: assert property (p_indir_dmem)
    else $error("Indirect write did not reach display memory.");

  property p_type_a_flip;
    @(posedge CLK) disable iff (!NRST)
      !wave_type && !LCD_RESET && tick && !(WR && ADDR == ADDR_CTRL)
        |=> pol != $past(pol);
  endproperty
  a_type_a_flip: assert property (p_type_a_flip)
    else $error("Type A polarity did not flip on a tick.");

  property p_slot_step;
    @(posedge CLK) disable iff (!NRST)
      !LCD_RESET && !tick |=> $stable(slot);
  endproperty
  a_slot_step: assert property (p_slot_step)
    else $error("Common slot moved without a tick.");

  property p_live_seg;
    @(posedge CLK) disable iff (!NRST)
      select_all[2] && !LCD_RESET
        |=> (SEG_LEVEL[5:4] inside {LVL_A, LVL_GND}) == $past(dmem[2][slot]);
  endproperty
  a_live_seg: assert property (p_live_seg)
    else $error("Segment drive does not follow display memory.");

  property p_cmos_out;
    @(posedge CLK) disable iff (!NRST)
      !select_all[1] |=> SEG_CMOS_OUT[1] == $past(dmem[1][0]);
  endproperty
  a_cmos_out: assert property (p_cmos_out)
    else $error("CMOS output level differs from display memory.");

  property p_seg_mode;
    @(posedge CLK) disable iff (!NRST)
      select_all[1] |=> !SEG_CMOS_EN[1] && !SEG_CMOS_OUT[1];
  endproperty
  a_seg_mode: assert property (p_seg_mode)
    else $error("Segment-selected pin still acts as CMOS output.");
endmodule // lcd_driver

// ==== hw/lcd_pkg.sv ====
// Functional notes
// - Scanner reads display memory every slot; writes show without further action.
// - Direct accesses in the display range go to bank 0 general memory.
// - Display enable acts in normal, slow, idle; sleep forces display off.
// - Control bit 7 picks waveform: 0 type A, 1 type B.
// - Two select registers choose segment drive or CMOS output per pin.
// - A CMOS-selected segment pin outputs its display memory bit.
// - Select bits mean 0 general output, 1 segment; all reset to 1.
// - LCD reset is high in sleep or while display enable is 0.
// - Display enable 0 stops all panel drive, blanking the display.
// - LCD clock is the sub-clock divided by 8, about 4 kHz.
// - Quarter duty: four commons, four slots per frame.
// - Type B runs at lower signal frequency than type A.
// - Drive averages to zero DC across every pixel.
// - Third bias: each output picks one of four levels per half slot.
// - Power-on reset clears display enable to 0.
package lcd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PORTC   = 8'h01;
  localparam logic [7:0] ADDR_PORTD   = 8'h02;
  localparam logic [7:0] ADDR_BANK    = 8'h03;
  localparam logic [7:0] ADDR_POINTER = 8'h04;
  localparam logic [7:0] ADDR_INDIR   = 8'h05;
  localparam logic [7:0] DMEM_BASE    = 8'h40;
  localparam logic [7:0] DMEM_LAST    = 8'h4F;
  localparam logic [7:0] BANK_DISPLAY = 8'h01;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_TYPE_BIT = 7;
  localparam logic [7:0] CTRL_MASK   = 8'h81;
  localparam logic [7:0] SELECT_RST  = 8'hFF;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam int DMEM_WORDS = 16;
  localparam int GMEM_WORDS = 256;
  localparam int NUM_COM = 4;
  localparam int NUM_SEG = 16;
  localparam int SUB_DIV = 8;
  // Drive levels: ground and three bias steps, VC < VB < VA.
  typedef enum logic [1:0] {LVL_GND, LVL_C, LVL_B, LVL_A} level_t;
endpackage

// ==== hw/lcd_sub_tick.sv ====
`timescale 1ns/100ps
module lcd_sub_tick
  import lcd_pkg::*;
#(
  parameter int DIV = lcd_pkg::SUB_DIV
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic SUB_CLOCK,
  output logic      TICK
);
  logic       sync1;
  logic       sync2;
  logic       prev;
  logic [3:0] cnt;
  wire        rise = sync2 & ~prev;

  // The sub-clock is foreign, so it is sampled twice before edge detection.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end else begin
      sync1 <= SUB_CLOCK;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cnt  <= 4'h0;
      TICK <= 1'b0;
    end else begin
      TICK <= 1'b0;
      if (rise) begin
        if (cnt == 4'(DIV - 1)) begin
          cnt  <= 4'h0;
          TICK <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // lcd_sub_tick

// ==== hw/lcd_wave_gen.sv ====
`timescale 1ns/100ps
module lcd_wave_gen
  import lcd_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        TICK,
  input  wire logic        LCD_RESET,
  input  wire logic        WAVE_TYPE,
  output logic [1:0]       SLOT,
  output logic             PHASE,
  output logic             POL
);
  logic frame_pol;

  // Each slot has two halves; type A flips in the middle of every slot,
  // type B holds polarity for a whole frame and flips per frame, so its
  // signal frequency is lower for the same LCD clock.
  always_ff @(posedge CLK) begin
    if (!NRST || LCD_RESET) begin
      SLOT      <= 2'h0;
      PHASE     <= 1'b0;
      frame_pol <= 1'b0;
    end else if (TICK) begin
      PHASE <= ~PHASE;
      if (PHASE) begin
        SLOT <= SLOT + 2'h1;
        if (SLOT == 2'(NUM_COM - 1)) begin
          frame_pol <= ~frame_pol;
        end
      end
    end
  end

  assign POL = WAVE_TYPE ? frame_pol : PHASE;
endmodule // lcd_wave_gen

// ==== tb/lcd_panel.sv ====
`timescale 1ns/100ps
module lcd_panel (
  input  wire logic        CLK,
  input  wire logic [7:0]  COM_LEVEL,
  input  wire logic [31:0] SEG_LEVEL,
  output int               dc [64]
);
  initial dc = '{default: 0};
  // Each pixel sums common minus segment level every cycle.
  // Levels are equal bias steps, so the sums are the DC stress.
  always @(posedge CLK) begin
    for (int c = 0; c < 4; c++)
      for (int g = 0; g < 16; g++)
        dc[16*c+g] <= dc[16*c+g] + int'(COM_LEVEL[2*c+:2])
                      - int'(SEG_LEVEL[2*g+:2]);
  end
endmodule // lcd_panel

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
  import lcd_pkg::*;
  localparam logic [1:0] LG = LVL_GND;
  localparam logic [1:0] LC = LVL_C;
  localparam logic [1:0] LB = LVL_B;
  localparam logic [1:0] LA = LVL_A;
  logic        CLK, NRST, SUB_CLOCK, SLEEP, WR, RD, LCD_RESET, rd_d, mon_on;
  logic [7:0]  ADDR, WDATA, RDATA, COM_LEVEL, pc, pd;
  logic [31:0] SEG_LEVEL;
  logic [15:0] SEG_CMOS_EN, SEG_CMOS_OUT, em;
  logic [3:0]  dm [16];
  logic [1:0]  pv;
  logic [7:0]  exp_q [$];
  logic [7:0]  exp_r;
  int          dc [64];
  int          errors, checks, flips, na, seed;

  lcd_driver i_lcd_driver (.CLK(CLK), .NRST(NRST), .SUB_CLOCK(SUB_CLOCK),
    .SLEEP(SLEEP), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LCD_RESET(LCD_RESET), .COM_LEVEL(COM_LEVEL),
    .SEG_LEVEL(SEG_LEVEL), .SEG_CMOS_EN(SEG_CMOS_EN),
    .SEG_CMOS_OUT(SEG_CMOS_OUT));
  lcd_panel i_lcd_panel (.CLK(CLK), .COM_LEVEL(COM_LEVEL),
    .SEG_LEVEL(SEG_LEVEL), .dc(dc));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Sub-clock far faster than 32768 Hz so a frame fits in 512 cycles.
  initial begin
    SUB_CLOCK = 1'b0;
    forever #40 SUB_CLOCK = ~SUB_CLOCK;
  end

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    RD <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ADDR <= a;
    RD <= 1'b1;
    WR <= 1'b0;
    exp_q.push_back(e);
    @(posedge CLK);
  endtask
  task automatic idle(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge CLK);
  endtask
  task automatic frame_start();
    logic [1:0] p;
    p = COM_LEVEL[1:0];
    for (int i = 0; i < 4000; i++) begin
      @(posedge CLK);
      if (COM_LEVEL[1:0] == LA && p inside {LB, LC}) return;
      p = COM_LEVEL[1:0];
    end
    errors++;
    print_verdict();
  endtask
  task automatic wave_test(input logic [7:0] ctrl);
    int  snap [64];
    logic ok;
    wr(ADDR_CTRL, ctrl);
    idle(5);
    mon_on <= 1'b1;
    frame_start();
    snap = dc;
    frame_start();
    ok = 1'b1;
    foreach (snap[i]) if (dc[i] != snap[i]) ok = 1'b0;
    `CHK(ok, 1'b1)
    flips <= 0;
    idle(1024);
    mon_on <= 1'b0;
    $display("test wave %0h done", ctrl);
  endtask

  always @(posedge CLK) rd_d <= RD & NRST;
  // The note is taken off the queue once, so a mismatch cannot pop twice.
  always @(negedge CLK) begin
    if (rd_d) begin
      exp_r = exp_q.pop_front();
      `CHK(RDATA, exp_r)
    end
  end
  always @(negedge CLK) begin
    int          sel;
    logic        p;
    logic [7:0]  ec;
    logic [31:0] es;
    if (mon_on) begin
      sel = 0;
      for (int c = 0; c < 4; c++)
        if (COM_LEVEL[2*c+:2] inside {LA, LG}) sel = c;
      p = (COM_LEVEL[2*sel+:2] == LG);
      for (int c = 0; c < 4; c++)
        ec[2*c+:2] = (c == sel) ? (p ? LG : LA) : (p ? LB : LC);
      for (int g = 0; g < 16; g++)
        es[2*g+:2] = dm[g][sel] ? (p ? LA : LG) : (p ? LC : LB);
      `CHK({COM_LEVEL, SEG_LEVEL}, {ec, es})
      if (COM_LEVEL[1:0] != pv) flips++;
    end
    pv = COM_LEVEL[1:0];
  end

  initial begin
    seed = 32'h9a78;
    {NRST, SLEEP, WR, RD, mon_on, ADDR, WDATA} = '0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    `CHK(LCD_RESET, 1'b1)
    `CHK({COM_LEVEL, SEG_LEVEL, SEG_CMOS_EN}, 56'h0)
    rd(ADDR_CTRL, ZERO8);
    rd(ADDR_PORTC, SELECT_RST);
    rd(ADDR_PORTD, SELECT_RST);
    wr(ADDR_BANK, BANK_DISPLAY);
    for (int i = 0; i < 16; i++) begin
      dm[i] = 4'($random(seed));
      wr(ADDR_POINTER, 8'(DMEM_BASE + i));
      wr(ADDR_INDIR, {4'h0, dm[i]});
    end
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_POINTER, 8'(DMEM_BASE + i));
      rd(ADDR_INDIR, {4'h0, dm[i]});
    end
    wr(DMEM_BASE, 8'hA5);
    rd(DMEM_BASE, 8'hA5);
    wr(ADDR_POINTER, DMEM_BASE);
    rd(ADDR_INDIR, {4'h0, dm[0]});
    wr(ADDR_CTRL, 8'hFF);
    rd(ADDR_CTRL, CTRL_MASK);
    $display("test registers done");
    wave_test(8'h01);
    na = flips;
    dm[0] = ~dm[0];
    wr(ADDR_INDIR, {4'h0, dm[0]});
    wave_test(8'h81);
    `CHK(flips < na, 1'b1)
    SLEEP <= 1'b1;
    idle(6);
    `CHK(LCD_RESET, 1'b1)
    `CHK({COM_LEVEL, SEG_LEVEL}, 40'h0)
    SLEEP <= 1'b0;
    idle(6);
    `CHK(LCD_RESET, 1'b0)
    wr(ADDR_CTRL, ZERO8);
    idle(4);
    `CHK(LCD_RESET, 1'b1)
    `CHK({COM_LEVEL, SEG_LEVEL}, 40'h0)
    $display("test sleep done");
    for (int i = 0; i < 16; i++) em[i] = dm[i][0];
    repeat (4) begin
      pc = 8'($random(seed));
      pd = 8'($random(seed));
      wr(ADDR_PORTC, pc);
      wr(ADDR_PORTD, pd);
      rd(ADDR_PORTC, pc);
      rd(ADDR_PORTD, pd);
      idle(3);
      `CHK(SEG_CMOS_EN, ~{pd, pc})
      `CHK(SEG_CMOS_OUT & SEG_CMOS_EN, em & ~{pd, pc})
    end
    $display("test select done");
    idle(3);
    print_verdict();
  end
endmodule // tb_top
